//--- lcdsd_pkg.sv
// constants of the segment lcd control block: register map, fields, encodings
// assumes a plain strobe register port and one system clock
package lcdsd_pkg;
   localparam logic [1:0] LCDSD_ADDR_CTRL_A = 2'h0;
   localparam logic [1:0] LCDSD_ADDR_CTRL_B = 2'h1;
   localparam logic [1:0] LCDSD_ADDR_DATA = 2'h2;
   localparam logic [1:0] LCDSD_ADDR_CONTRAST = 2'h3;
   localparam int A_EN = 7;
   localparam int A_LPW = 6;
   localparam int A_FLAG = 4;
   localparam int A_IE = 3;
   localparam int A_BLANK = 0;
   localparam int B_CS = 7;
   localparam int B_HALF = 6;
   localparam int B_DUTY_HI = 5;
   localparam int B_DUTY_LO = 4;
   localparam int B_PM_HI = 2;
   localparam logic [7:0] CTRL_A_WMASK = 8'hc9;
   localparam logic [7:0] CTRL_B_WMASK = 8'hf7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int NUM_SEG = 25;
   localparam int NUM_COM = 4;
   localparam logic [1:0] DUTY_STATIC = 2'h0;
   localparam logic [1:0] BIAS_STATIC = 2'h0;
   localparam logic [1:0] BIAS_THIRD = 2'h1;
   localparam logic [1:0] BIAS_HALF = 2'h2;
   localparam logic [4:0] SEG_COUNT [8] = '{5'd13, 5'd15, 5'd17, 5'd19,
                                          5'd21, 5'd23, 5'd24, 5'd25};
endpackage

//--- lcdsd_ctrl.sv
// control and status logic of the segment lcd driver
// assumes frame timing generator outside gives a frame_tick pulse on clk_sys
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module lcdsd_ctrl
   import lcdsd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // system
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire logic ext_clock_input_enable,
   input wire logic frame_tick,
   output logic frame_irq,
   output logic frame_latch,
   // clock selection
   output logic lcd_clock_source_select,
   output logic async_from_external,
   // drive state
   output logic lcd_active,
   output logic low_power_wave_active,
   output logic blank_active,
   output logic [1:0] bias_mode,
   output logic [1:0] duty_select,
   output logic [7:0] display_data_latched,
   output logic [7:0] contrast_latched,
   output logic [NUM_COM-1:0] com_lcd_owned,
   output logic [NUM_SEG-1:0] seg_lcd_owned
);
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [7:0] display_data;
   logic [7:0] contrast;
   logic flag;
   logic odd_frame;
   logic frame_start;
   logic flag_event;
   logic wr_a;

   assign wr_a = clk_en && reg_wr && reg_addr == LCDSD_ADDR_CTRL_A;
   // low-power waveform uses the latched selection to skip every second frame
   assign frame_start = clk_en && ctrl_a[A_EN] && frame_tick
      && (!low_power_wave_active || odd_frame);
   assign flag_event = frame_start;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_a <= CTRL_RESET;
         ctrl_b <= CTRL_RESET;
         display_data <= 8'h00;
         contrast <= 8'h00;
      end
      else if (clk_en && reg_wr)
      begin
         case (reg_addr)
            LCDSD_ADDR_CTRL_A: ctrl_a <= reg_wdata & CTRL_A_WMASK;
            LCDSD_ADDR_CTRL_B: ctrl_b <= reg_wdata & CTRL_B_WMASK;
            LCDSD_ADDR_DATA: display_data <= reg_wdata;
            default: contrast <= reg_wdata;
         endcase
      end
   end

   // sticky frame flag, set wins over clear
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         flag <= 1'b0;
      else if (flag_event)
         flag <= 1'b1;
      else if (clk_en && (irq_vector_ack || (wr_a && reg_wdata[A_FLAG])))
         flag <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         odd_frame <= 1'b0;
      else if (clk_en && !ctrl_a[A_EN])
         odd_frame <= 1'b0;
      else if (clk_en && frame_tick)
         odd_frame <= !odd_frame;
   end

   // working copies taken at frame start
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         low_power_wave_active <= 1'b0;
         blank_active <= 1'b0;
         display_data_latched <= 8'h00;
         contrast_latched <= 8'h00;
      end
      else if (clk_en && ctrl_a[A_EN] && frame_tick && (!low_power_wave_active || odd_frame))
      begin
         low_power_wave_active <= ctrl_a[A_LPW];
         blank_active <= ctrl_a[A_BLANK];
         display_data_latched <= display_data;
         contrast_latched <= contrast;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         frame_latch <= 1'b0;
      else if (clk_en)
         frame_latch <= frame_start;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            LCDSD_ADDR_CTRL_A: reg_rdata <= (ctrl_a & CTRL_A_WMASK) | {3'h0, flag, 4'h0};
            LCDSD_ADDR_CTRL_B: reg_rdata <= ctrl_b & CTRL_B_WMASK;
            LCDSD_ADDR_DATA: reg_rdata <= display_data;
            default: reg_rdata <= contrast;
         endcase
      end
   end

   assign lcd_active = ctrl_a[A_EN];
   assign frame_irq = flag && ctrl_a[A_IE] && global_irq_enable;
   assign lcd_clock_source_select = ctrl_b[B_CS];
   assign async_from_external = ext_clock_input_enable;
   assign duty_select = ctrl_b[B_DUTY_HI:B_DUTY_LO];
   assign bias_mode = (duty_select == DUTY_STATIC) ? BIAS_STATIC :
                      (ctrl_b[B_HALF] ? BIAS_HALF : BIAS_THIRD);

   // pin ownership: disabled gives every pin back to the port
   always_comb
   begin
      com_lcd_owned = '0;
      seg_lcd_owned = '0;
      for (int i = 0; i < NUM_COM; i++)
         com_lcd_owned[i] = lcd_active && (i <= int'(duty_select));
      for (int j = 0; j < NUM_SEG; j++)
         seg_lcd_owned[j] = lcd_active && (j < int'(SEG_COUNT[ctrl_b[B_PM_HI:0]]));
   end

   property p_flag_set;
      @(posedge clk_sys) disable iff (sys_rst) flag_event |=> flag;
   endproperty
   AST_FLAG_SET: assert property (p_flag_set) else $error("flag not set");

   AST_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !flag_event && irq_vector_ack) |=> !flag) else $error("flag not cleared");

   AST_FLAG_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (flag && !(clk_en && (irq_vector_ack || (wr_a && reg_wdata[A_FLAG])))) |=> flag)
      else $error("flag lost");

   AST_IRQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
      frame_irq == (flag && ctrl_a[A_IE] && global_irq_enable)) else $error("irq wrong");

   AST_OFF_PINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !lcd_active |-> (seg_lcd_owned == '0 && com_lcd_owned == '0)) else $error("pins held");

   sequence s_disable_write;
      wr_a && !reg_wdata[A_EN];
   endsequence
   AST_STOP_NOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_disable_write |=> !lcd_active) else $error("not stopped");

   AST_WAVE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !frame_start |=> $stable(low_power_wave_active)) else $error("wave changed midframe");

   AST_SEG_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
      lcd_active |-> (seg_lcd_owned[12] && (seg_lcd_owned[24] == (ctrl_b[2:0] == 3'h7))))
      else $error("seg mask wrong");

   AST_STATIC_BIAS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      duty_select == DUTY_STATIC |-> bias_mode == BIAS_STATIC) else $error("bias wrong");

   AST_RSVD: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && reg_rd) |=> (reg_rdata[3] == 1'b0 || $past(reg_addr) != LCDSD_ADDR_CTRL_B))
      else $error("reserved bit read");
endmodule

//--- lcdsd_glass.sv
// frame timer standing in for the far side of the lcd control block
// assumes one clock; ticks only while the driver is active
`timescale 1ns/1ps
module lcdsd_glass #(parameter int PERIOD = 8)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // driver state
   input wire logic lcd_active,
   // frame timing
   output logic frame_tick
);
   int cnt;
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt <= 0;
         frame_tick <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == PERIOD - 1 || !lcd_active) ? 0 : cnt + 1;
         frame_tick <= lcd_active && cnt == PERIOD - 1;
      end
   end
endmodule

//--- lcd_segment_driver_control_tb.sv
// testbench of the segment lcd control block
// assumes the frame timer model supplies frame ticks
`timescale 1ns/1ps
module lcd_segment_driver_control_tb;
   import lcdsd_pkg::*;
   logic clk_sys = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, gie = 0, ack = 0, ext = 0;
   logic [1:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, d, r, dd, cc, display_data_latched, contrast_latched;
   logic frame_tick, frame_irq, frame_latch, lcd_clock_source_select, async_from_external;
   logic lcd_active, low_power_wave_active, blank_active;
   logic [1:0] bias_mode, duty_select;
   logic [3:0] com_lcd_owned;
   logic [24:0] seg_lcd_owned;
   int failures = 0, n_tests = 0, nt = 0, nl = 0;
   logic cnt = 0;
   always #25 clk_sys = ~clk_sys;
   lcdsd_ctrl DUT (.clk_sys, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .global_irq_enable(gie), .irq_vector_ack(ack), .ext_clock_input_enable(ext),
      .frame_tick, .frame_irq, .frame_latch, .lcd_clock_source_select, .async_from_external,
      .lcd_active, .low_power_wave_active, .blank_active, .bias_mode, .duty_select,
      .display_data_latched, .contrast_latched, .com_lcd_owned, .seg_lcd_owned);
   lcdsd_glass GL (.clk_sys, .sys_rst, .lcd_active, .frame_tick);
   always @(posedge clk_sys)
   begin
      if (cnt)
      begin
         nt += frame_tick;
         nl += frame_latch;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wf();
      int i = 0;
      do
      begin
         @(posedge clk_sys);
         #1 i++;
      end
      while (frame_latch !== 1'b1 && i < 100);
      chk(frame_latch, 1);
   endtask
   function automatic logic [1:0] bias_e(input logic [1:0] m, input logic h);
      return (m == 2'h0) ? 2'h0 : (h ? 2'h2 : 2'h1);
   endfunction
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #200000;
      failures++;
      conclude();
   end
   initial
   begin
      void'($urandom(41));
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(LCDSD_ADDR_CTRL_A, r);
      chk(r, 8'h00);
      rd(LCDSD_ADDR_CTRL_B, r);
      chk(r, 8'h00);
      chk(com_lcd_owned, 4'h0);
      wr(LCDSD_ADDR_CTRL_A, 8'hae);
      rd(LCDSD_ADDR_CTRL_A, r);
      chk(r, 8'h88);
      for (int i = 0; i < 8; i++)
      begin
         d = {2'($urandom), 2'(i), 1'($urandom), 3'(i)};
         ext <= 1'($urandom);
         wr(LCDSD_ADDR_CTRL_B, d);
         rd(LCDSD_ADDR_CTRL_B, r);
         chk(r, d & 8'hf7);
         chk(lcd_clock_source_select, d[7]);
         chk(async_from_external, ext);
         chk(duty_select, d[5:4]);
         chk(bias_mode, bias_e(d[5:4], d[6]));
         chk(com_lcd_owned, 4'((5'h2 << d[5:4]) - 5'h1));
         chk(seg_lcd_owned, 25'((26'h1 << SEG_COUNT[d[2:0]]) - 26'h1));
      end
      gie <= 1'b1;
      wr(LCDSD_ADDR_CTRL_A, 8'h98);
      wf();
      rd(LCDSD_ADDR_CTRL_A, r);
      chk(r, 8'h98);
      chk(frame_irq, 1);
      wr(LCDSD_ADDR_CTRL_A, 8'h88);
      gie <= 1'b0;
      rd(LCDSD_ADDR_CTRL_A, r);
      chk(r, 8'h98);
      chk(frame_irq, 0);
      wf();
      ack <= 1'b1;
      @(posedge clk_sys);
      ack <= 1'b0;
      rd(LCDSD_ADDR_CTRL_A, r);
      chk(r, 8'h88);
      wf();
      dd = 8'($urandom);
      cc = 8'($urandom);
      wr(LCDSD_ADDR_DATA, dd);
      wr(LCDSD_ADDR_CONTRAST, cc);
      wr(LCDSD_ADDR_CTRL_A, 8'hc8);
      chk(low_power_wave_active, 0);
      wf();
      chk(low_power_wave_active, 1);
      chk({display_data_latched, contrast_latched}, {dd, cc});
      clk_en <= 1'b0;
      wr(LCDSD_ADDR_DATA, ~dd);
      clk_en <= 1'b1;
      rd(LCDSD_ADDR_DATA, r);
      chk(r, dd);
      cnt <= 1'b1;
      repeat (160) @(posedge clk_sys);
      cnt <= 1'b0;
      chk(nt >= 16 && 2 * nl >= nt - 1 && 2 * nl <= nt + 1, 1);
      wf();
      wr(LCDSD_ADDR_CTRL_A, 8'hd1);
      chk(blank_active, 0);
      wf();
      chk(blank_active, 1);
      wr(LCDSD_ADDR_CTRL_A, 8'h00);
      chk({lcd_active, com_lcd_owned, seg_lcd_owned}, 30'h0);
      conclude();
   end
endmodule
